// >>> rtl/acmp_edge.sv
/*
 * Event detector on the synchronised comparator result.
 * Assumes sample_in is a register on mclk_in.
 */
`timescale 1ns/10ps
module acmp_edge
	import acmp_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Sample and mode
	input wire logic sample_in,
	input wire acmp_mode_t mode_in,
	// Event
	output logic event_out
);
	logic prev_q;

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sample_in;
		end
	end

	always_comb begin
		unique case (mode_in)
			ACMP_MODE_TOGGLE: event_out = sample_in ^ prev_q;
			ACMP_MODE_FALL: event_out = prev_q & ~sample_in;
			ACMP_MODE_RISE: event_out = sample_in & ~prev_q;
			ACMP_MODE_RSVD: event_out = 1'b0;
		endcase
	end
endmodule // acmp_edge

// >>> rtl/acmp_pins_if.sv
/*
 * Synchronised analog input levels passed from the pin synchroniser to the control block.
 * Assumes all users run on mclk_in.
 */
`timescale 1ns/10ps
interface acmp_pins_if;
	import acmp_pkg::*;
	acmp_level_t pos;
	acmp_level_t neg;
	acmp_level_t conv [8];
	modport src (output pos, output neg, output conv);
	modport dst (input pos, input neg, input conv);
endinterface

// >>> rtl/acmp_pkg.sv
/*
 * Types shared by the comparator control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acmp_pkg;

	typedef enum logic [1:0] {
		ACMP_MODE_TOGGLE = 2'h0,
		ACMP_MODE_RSVD = 2'h1,
		ACMP_MODE_FALL = 2'h2,
		ACMP_MODE_RISE = 2'h3
	} acmp_mode_t;

	typedef logic [7:0] acmp_level_t;

endpackage

// >>> rtl/acmp_regs.svh
/*
 * Offsets, field positions, reset values and widths of the comparator control block.
 * Assumes inclusion by files that compile after it; definitions only.
 */
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACMP_SFIO_OFS 8'h00
`define ACMP_CCS_OFS 8'h04
`define ACMP_STAT_OFS 8'h08
`define ACMP_MASK_OFS 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACMP_SFIO_MUXEN 3
`define ACMP_CCS_DIS 7
`define ACMP_CCS_BG 6
`define ACMP_CCS_RES 5
`define ACMP_CCS_FLAG 4
`define ACMP_CCS_IEN 3
`define ACMP_CCS_CAP 2
`define ACMP_CCS_MODE_HI 1
`define ACMP_CCS_MODE_LO 0
`define ACMP_STAT_EVT 0

// ----------------------------------------
// Reset values, widths and the bandgap level code
// ----------------------------------------
`define ACMP_SFIO_RST 8'h00
`define ACMP_CCS_RST 8'h00
`define ACMP_VW 8
`define ACMP_NCH 8
`define ACMP_BANDGAP_CODE 8'h80

`endif

// >>> rtl/acmp_sync.sv
/*
 * Two-stage synchroniser for every analog input level code.
 * Assumes pins_in arrives asynchronously; lane 0 positive, 1 negative, 2..9 converter pins.
 */
`timescale 1ns/10ps
module acmp_sync
	import acmp_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Raw pin levels
	input wire logic [79:0] pins_in,
	// Synchronised levels
	acmp_pins_if.src pins
);
	genvar i;
	for (i = 0; i < 10; i++) begin : g_lane
		acmp_level_t s1_q;
		acmp_level_t s2_q;
		always_ff @(posedge mclk_in) begin
			if (!resetn_in) begin
				s1_q <= 8'h00;
				s2_q <= 8'h00;
			end else begin
				s1_q <= pins_in[i*8 +: 8];
				s2_q <= s1_q;
			end
		end
		if (i == 0) begin : g_pos
			assign pins.pos = s2_q;
		end else if (i == 1) begin : g_neg
			assign pins.neg = s2_q;
		end else begin : g_conv
			assign pins.conv[i-2] = s2_q;
		end
	end
endmodule // acmp_sync

// >>> rtl/acmp_top.sv
/*
 * Analog comparator control: input selection, power-down, result synchronisation,
 * edge interrupt flag, timer capture routing and an APB register slave.
 * Assumes analog levels arrive as 8-bit codes, and converter enable, channel field,
 * global enable and vector acknowledge come from logic on mclk_in.
 */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "acmp_regs.svh"
module acmp_top
	import acmp_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// APB slave
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Analog level codes
	input wire logic [7:0] positive_input_pin_in,
	input wire logic [7:0] negative_input_pin_in,
	input wire logic [63:0] converter_input_pins_in,
	// Neighbouring logic
	input wire logic converter_enable_in,
	input wire logic [2:0] channel_select_field_in,
	input wire logic global_irq_enable_in,
	input wire logic irq_vector_ack_in,
	// Requests
	output logic comparator_irq_out,
	output logic capture_trigger_out,
	output logic irq_out
);
	// ----------------------------------------
	// Input synchronisation and selection
	// ----------------------------------------
	acmp_pins_if pins ();

	acmp_sync u_sync (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.pins_in({converter_input_pins_in, negative_input_pin_in, positive_input_pin_in}),
		.pins(pins)
	);

	logic negative_mux_enable_q;
	logic comparator_disable_q;
	logic bandgap_select_q;
	logic comparator_irq_enable_q;
	logic capture_route_enable_q;
	acmp_mode_t irq_mode_q;
	logic comparator_irq_flag_q;
	logic comparator_result_q;
	logic stat_q;
	logic mask_q;
	acmp_level_t pos_sel;
	acmp_level_t neg_sel;
	logic use_mux;

	assign use_mux = negative_mux_enable_q & ~converter_enable_in;
	assign neg_sel = use_mux ? pins.conv[channel_select_field_in] : pins.neg;
	assign pos_sel = bandgap_select_q ? `ACMP_BANDGAP_CODE : pins.pos;

	// Powered-off comparator reads low, so toggling disable can raise an event
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			comparator_result_q <= 1'b0;
		end else begin
			comparator_result_q <= ~comparator_disable_q & (pos_sel > neg_sel);
		end
	end

	// ----------------------------------------
	// Event detection and flags
	// ----------------------------------------
	logic evt;

	acmp_edge u_edge (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.sample_in(comparator_result_q),
		.mode_in(irq_mode_q),
		.event_out(evt)
	);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic acc;
	logic wr;
	logic rd;
	logic hit;

	assign acc = psel_in & penable_in & pready_out;
	assign wr = acc & pwrite_in;
	assign rd = acc & ~pwrite_in;
	assign hit = (paddr_in == `ACMP_SFIO_OFS) || (paddr_in == `ACMP_CCS_OFS) ||
		(paddr_in == `ACMP_STAT_OFS) || (paddr_in == `ACMP_MASK_OFS);

	// Set wins over every clear source
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			comparator_irq_flag_q <= 1'b0;
		end else if (evt) begin
			comparator_irq_flag_q <= 1'b1;
		end else if (irq_vector_ack_in ||
			(wr && paddr_in == `ACMP_CCS_OFS && pwdata_in[`ACMP_CCS_FLAG])) begin
			comparator_irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			stat_q <= 1'b0;
		end else if (evt) begin
			stat_q <= 1'b1;
		end else if (rd && paddr_in == `ACMP_STAT_OFS) begin
			stat_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			negative_mux_enable_q <= 1'(`ACMP_SFIO_RST >> `ACMP_SFIO_MUXEN);
		end else if (wr && paddr_in == `ACMP_SFIO_OFS) begin
			negative_mux_enable_q <= pwdata_in[`ACMP_SFIO_MUXEN];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			{comparator_disable_q, bandgap_select_q} <= 2'h0;
			{comparator_irq_enable_q, capture_route_enable_q} <= 2'h0;
			irq_mode_q <= ACMP_MODE_TOGGLE;
		end else if (wr && paddr_in == `ACMP_CCS_OFS) begin
			comparator_disable_q <= pwdata_in[`ACMP_CCS_DIS];
			bandgap_select_q <= pwdata_in[`ACMP_CCS_BG];
			comparator_irq_enable_q <= pwdata_in[`ACMP_CCS_IEN];
			capture_route_enable_q <= pwdata_in[`ACMP_CCS_CAP];
			irq_mode_q <= acmp_mode_t'(pwdata_in[`ACMP_CCS_MODE_HI:`ACMP_CCS_MODE_LO]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			mask_q <= 1'b0;
		end else if (wr && paddr_in == `ACMP_MASK_OFS) begin
			mask_q <= pwdata_in[`ACMP_STAT_EVT];
		end
	end

	// Answer registered in setup, so every access completes with no wait state
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end else begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~hit;
			prdata_out <= 32'h00000000;
			if (psel_in && !penable_in && !pwrite_in) begin
				unique case (paddr_in)
					`ACMP_SFIO_OFS: prdata_out[`ACMP_SFIO_MUXEN] <= negative_mux_enable_q;
					`ACMP_CCS_OFS: prdata_out[7:0] <= {comparator_disable_q, bandgap_select_q,
						comparator_result_q, comparator_irq_flag_q, comparator_irq_enable_q,
						capture_route_enable_q, irq_mode_q};
					`ACMP_STAT_OFS: prdata_out[`ACMP_STAT_EVT] <= stat_q;
					`ACMP_MASK_OFS: prdata_out[`ACMP_STAT_EVT] <= mask_q;
					default: prdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Requests
	// ----------------------------------------
	// Timer path held low when unrouted; timer needs its own mask too
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			capture_trigger_out <= 1'b0;
		end else begin
			capture_trigger_out <= capture_route_enable_q & comparator_result_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			comparator_irq_out <= 1'b0;
		end else begin
			comparator_irq_out <= comparator_irq_flag_q & comparator_irq_enable_q & global_irq_enable_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= stat_q & mask_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	a_result_compare: assert property (!comparator_disable_q |=>
		comparator_result_q == $past(pos_sel > neg_sel)) else $error("result does not follow compare");
	a_mux_channel: assert property (negative_mux_enable_q && !converter_enable_in
		|-> neg_sel == pins.conv[channel_select_field_in]) else $error("mux channel not applied");
	a_mux_bypass: assert property ((!negative_mux_enable_q || converter_enable_in)
		|-> neg_sel == pins.neg) else $error("negative pin not applied");
	a_muxen_write: assert property (wr && paddr_in == `ACMP_SFIO_OFS |=>
		negative_mux_enable_q == $past(pwdata_in[`ACMP_SFIO_MUXEN])) else $error("mux enable write lost");
	a_disable_low: assert property (comparator_disable_q |=> !comparator_result_q)
		else $error("disabled comparator reads high");
	a_bandgap_pos: assert property (bandgap_select_q |-> pos_sel == `ACMP_BANDGAP_CODE)
		else $error("bandgap not selected");
	a_sync_latency: assert property (!comparator_disable_q && $rose(pos_sel > neg_sel)
		|=> comparator_result_q) else $error("sync latency wrong");
	a_rise_flag: assert property (irq_mode_q == ACMP_MODE_RISE && $rose(comparator_result_q)
		|=> comparator_irq_flag_q) else $error("rising edge missed");
	a_ack_clear: assert property (irq_vector_ack_in && !evt |=> !comparator_irq_flag_q)
		else $error("flag not cleared by vector");
	a_irq_gate: assert property (comparator_irq_out == $past(comparator_irq_flag_q &
		comparator_irq_enable_q & global_irq_enable_in)) else $error("irq gating wrong");
	a_capture_off: assert property (!capture_route_enable_q |=> !capture_trigger_out)
		else $error("capture not disconnected");
	a_capture_on: assert property (capture_route_enable_q && comparator_result_q
		|=> capture_trigger_out) else $error("capture not routed");
	a_rsvd_mode: assert property (irq_mode_q == ACMP_MODE_RSVD && !comparator_irq_flag_q
		|=> !comparator_irq_flag_q) else $error("reserved mode raised flag");
	a_fall_toggle: assert property (irq_mode_q == ACMP_MODE_FALL && comparator_result_q
		##1 !comparator_result_q && irq_mode_q == ACMP_MODE_FALL |=> comparator_irq_flag_q)
		else $error("falling edge missed");

	c_toggle_irq: cover property (irq_mode_q == ACMP_MODE_TOGGLE ##1 comparator_irq_out);
	c_mux_used: cover property (use_mux && comparator_result_q);
	c_set_clear: cover property (evt && irq_vector_ack_in);
	c_capture: cover property ($rose(capture_trigger_out));
	c_fall_event: cover property (irq_mode_q == ACMP_MODE_FALL && evt);

	// ----------------------------------------
	// Register path and flag assertions
	// ----------------------------------------
	a_w1c_clear: assert property (
		wr && paddr_in == `ACMP_CCS_OFS && pwdata_in[`ACMP_CCS_FLAG] && !evt |=> !comparator_irq_flag_q)
		else $error("flag not cleared by write one");
	a_flag_set: assert property (
		evt |=> comparator_irq_flag_q)
		else $error("event did not set flag");
	a_toggle_flag: assert property (
		irq_mode_q == ACMP_MODE_TOGGLE && $changed(comparator_result_q) |=> comparator_irq_flag_q)
		else $error("toggle event missed");
	a_no_spurious: assert property (
		!evt && !comparator_irq_flag_q |=> !comparator_irq_flag_q)
		else $error("flag set without event");
	a_flag_hold: assert property (
		comparator_irq_flag_q && !irq_vector_ack_in && !(wr && paddr_in == `ACMP_CCS_OFS) |=> comparator_irq_flag_q)
		else $error("flag lost without clear");
	a_ien_off: assert property (
		!comparator_irq_enable_q |=> !comparator_irq_out)
		else $error("request while enable clear");
	a_global_off: assert property (
		!global_irq_enable_in |=> !comparator_irq_out)
		else $error("request while global enable clear");
	a_ien_write: assert property (
		wr && paddr_in == `ACMP_CCS_OFS |=> comparator_irq_enable_q == $past(pwdata_in[`ACMP_CCS_IEN]))
		else $error("irq enable write lost");
	a_bandgap_off: assert property (
		!bandgap_select_q |-> pos_sel == pins.pos)
		else $error("positive pin not applied");
	a_disable_write: assert property (
		wr && paddr_in == `ACMP_CCS_OFS |=> comparator_disable_q == $past(pwdata_in[`ACMP_CCS_DIS]))
		else $error("disable write lost");
	a_result_read: assert property (
		psel_in && !penable_in && !pwrite_in && paddr_in == `ACMP_CCS_OFS
		|=> prdata_out[`ACMP_CCS_RES] == $past(comparator_result_q)) else $error("result read wrong");
	a_muxen_read: assert property (
		psel_in && !penable_in && !pwrite_in && paddr_in == `ACMP_SFIO_OFS
		|=> prdata_out[`ACMP_SFIO_MUXEN] == $past(negative_mux_enable_q)) else $error("mux enable read wrong");
	a_mode_write: assert property (
		wr && paddr_in == `ACMP_CCS_OFS |=> 2'(irq_mode_q) == $past(pwdata_in[1:0]))
		else $error("mode write lost");
	a_capture_follow: assert property (
		capture_trigger_out == $past(capture_route_enable_q & comparator_result_q))
		else $error("capture path lags wrongly");
	a_stat_set: assert property (
		evt |=> stat_q)
		else $error("status not set by event");
	a_stat_clear: assert property (
		rd && paddr_in == `ACMP_STAT_OFS && !evt |=> !stat_q)
		else $error("status not cleared by read");
	a_irq_level: assert property (
		irq_out == $past(stat_q & mask_q))
		else $error("interrupt level wrong");
	a_mask_write: assert property (
		wr && paddr_in == `ACMP_MASK_OFS |=> mask_q == $past(pwdata_in[`ACMP_STAT_EVT]))
		else $error("mask write lost");
	a_pready_pulse: assert property (
		pready_out |=> !pready_out)
		else $error("ready held over two cycles");
	a_slverr_ready: assert property (
		pslverr_out |-> pready_out)
		else $error("error without ready");
endmodule // acmp_top

// >>> tb/acmp_pins_model.sv
/*
 * Pin model: analog level codes on the comparator inputs and the timer capture front end.
 * Assumes the bench calls its tasks and that every level changes just after a rising edge.
 */
`timescale 1ns/10ps
module acmp_pins_model (
	// Clock
	input wire logic mclk_in,
	// Analog level codes
	output logic [7:0] pos_out,
	output logic [7:0] neg_out,
	output logic [63:0] conv_out,
	// Timer capture front end
	input wire logic capture_trigger_in
);
	logic cap_q = 1'b0;
	logic capture_irq_mask = 1'b1;
	int capture_edges = 0;
	initial begin
		pos_out = 8'h00;
		neg_out = 8'h00;
		conv_out = 64'h0;
	end
	task automatic drive(input logic [7:0] p, input logic [7:0] n);
		@(posedge mclk_in);
		pos_out <= p;
		neg_out <= n;
	endtask
	task automatic drive_conv(input logic [63:0] c);
		@(posedge mclk_in);
		conv_out <= c;
	endtask
	// ----------------------------------------
	// Capture edge selector
	// ----------------------------------------
	// Rising edges only; no interrupt is counted without the timer mask
	always @(posedge mclk_in) begin
		cap_q <= capture_trigger_in;
		if (capture_trigger_in && !cap_q && capture_irq_mask) begin
			capture_edges <= capture_edges + 1;
		end
	end
endmodule // acmp_pins_model

// >>> tb/analog_comparator_control_bench.sv
/*
 * Self-checking bench for the comparator control block.
 * Assumes the pin model supplies the analog codes; the bench is the APB master.
 */
`timescale 1ns/10ps
`include "acmp_regs.svh"
module analog_comparator_control_bench;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_en = 1'b0, gie = 1'b0, ack = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, cmp_irq, cap, irq;
	logic [2:0] chan = 3'h0;
	logic [7:0] pos, neg;
	logic [63:0] conv;
	logic [3:0] rise_exp = 4'h9, fall_exp = 4'h5;
	int fails = 0;
	int total_checks = 0;
	always #25 mclk_in = ~mclk_in;
	acmp_top uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .positive_input_pin_in(pos),
		.negative_input_pin_in(neg), .converter_input_pins_in(conv), .converter_enable_in(conv_en),
		.channel_select_field_in(chan), .global_irq_enable_in(gie), .irq_vector_ack_in(ack),
		.comparator_irq_out(cmp_irq), .capture_trigger_out(cap), .irq_out(irq));
	acmp_pins_model pins (.mclk_in(mclk_in), .pos_out(pos), .neg_out(neg), .conv_out(conv),
		.capture_trigger_in(cap));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Idle cycle first, so no signal is assigned twice in one time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			fails++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string s);
		apb(1'b0, a, 32'h0);
		check(rd & m, exp, s);
	endtask
	task automatic settle();
		repeat (6) @(posedge mclk_in);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rchk(`ACMP_SFIO_OFS, 32'hFFFFFFFF, 32'h0, "mux reset");
		rchk(`ACMP_CCS_OFS, 32'hFFFFFFFF, 32'h0, "ccs reset");
		apb(1'b1, `ACMP_SFIO_OFS, 32'hFF);
		rchk(`ACMP_SFIO_OFS, 32'hFFFFFFFF, 32'h8, "mux rw");
		apb(1'b0, 8'h10, 32'h0);
		check(32'(err), 32'h1, "unmapped err");
		check(rd, 32'h0, "unmapped data");
		apb(1'b1, `ACMP_SFIO_OFS, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_compare();
		int e;
		e = pins.capture_edges;
		pins.drive(8'h50, 8'h40);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h20, "result high");
		check(32'(cap), 32'h0, "route off");
		pins.drive(8'h40, 8'h40);
		apb(1'b1, `ACMP_CCS_OFS, 32'h04);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h0, "equal is low");
		pins.drive(8'h41, 8'h40);
		repeat (2) @(posedge mclk_in);
		check(32'(cap), 32'h0, "sync delay");
		repeat (3) @(posedge mclk_in);
		check(32'(cap), 32'h1, "route on");
		@(posedge mclk_in);
		check(pins.capture_edges, e + 1, "capture edge");
		apb(1'b1, `ACMP_CCS_OFS, 32'h10);
		$display("compare test done");
	endtask
	task automatic t_mux();
		pins.drive(8'h80, 8'hFF);
		apb(1'b1, `ACMP_SFIO_OFS, 32'h8);
		for (int k = 0; k < 8; k++) begin
			pins.drive_conv(~(64'hFF << (8 * k)));
			chan <= 3'(k);
			settle();
			rchk(`ACMP_CCS_OFS, 32'h20, 32'h20, "channel pick");
		end
		conv_en <= 1'b1;
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h0, "converter on");
		conv_en <= 1'b0;
		apb(1'b1, `ACMP_SFIO_OFS, 32'h0);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h0, "mux off");
		$display("mux test done");
	endtask
	task automatic t_bandgap_disable();
		pins.drive(8'h00, 8'h40);
		apb(1'b1, `ACMP_CCS_OFS, 32'h40);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h20, "bandgap above");
		pins.drive(8'h00, 8'hC0);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h0, "bandgap below");
		pins.drive(8'h90, 8'h10);
		apb(1'b1, `ACMP_CCS_OFS, 32'h80);
		settle();
		rchk(`ACMP_CCS_OFS, 32'hE0, 32'h80, "disabled");
		apb(1'b1, `ACMP_CCS_OFS, 32'h10);
		settle();
		rchk(`ACMP_CCS_OFS, 32'h20, 32'h20, "enabled");
		$display("bandgap test done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			pins.drive(8'h00, 8'h80);
			settle();
			apb(1'b1, `ACMP_CCS_OFS, 32'(m) | 32'h10);
			pins.drive(8'hFF, 8'h80);
			settle();
			rchk(`ACMP_CCS_OFS, 32'h13, {27'h0, rise_exp[m], 2'h0, 2'(m)}, "rise event");
			apb(1'b1, `ACMP_CCS_OFS, 32'(m) | 32'h10);
			rchk(`ACMP_CCS_OFS, 32'h10, 32'h0, "w1c flag");
			pins.drive(8'h00, 8'h80);
			settle();
			rchk(`ACMP_CCS_OFS, 32'h10, {27'h0, fall_exp[m], 4'h0}, "fall event");
		end
		$display("mode test done");
	endtask
	task automatic t_irq();
		apb(1'b1, `ACMP_CCS_OFS, 32'h13);
		apb(1'b1, `ACMP_MASK_OFS, 32'h1);
		apb(1'b0, `ACMP_STAT_OFS, 32'h0);
		gie <= 1'b1;
		pins.drive(8'hFF, 8'h80);
		settle();
		check(32'(cmp_irq), 32'h0, "enable off");
		check(32'(irq), 32'h1, "irq on");
		apb(1'b1, `ACMP_CCS_OFS, 32'h0B);
		repeat (2) @(posedge mclk_in);
		check(32'(cmp_irq), 32'h1, "request");
		gie <= 1'b0;
		repeat (2) @(posedge mclk_in);
		check(32'(cmp_irq), 32'h0, "global off");
		gie <= 1'b1;
		ack <= 1'b1;
		@(posedge mclk_in);
		ack <= 1'b0;
		repeat (2) @(posedge mclk_in);
		check(32'(cmp_irq), 32'h0, "vector clear");
		rchk(`ACMP_STAT_OFS, 32'hFFFFFFFF, 32'h1, "status sticky");
		repeat (2) @(posedge mclk_in);
		check(32'(irq), 32'h0, "read clears");
		apb(1'b1, `ACMP_CCS_OFS, 32'h13);
		apb(1'b1, `ACMP_MASK_OFS, 32'h0);
		pins.drive(8'h00, 8'h80);
		pins.drive(8'hFF, 8'h80);
		settle();
		check(32'(irq), 32'h0, "masked");
		rchk(`ACMP_STAT_OFS, 32'hFFFFFFFF, 32'h1, "masked status");
		$display("irq test done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
		t_reset();
		t_compare();
		t_mux();
		t_bandgap_disable();
		t_modes();
		t_irq();
		conclude();
	end
	initial begin
		#2000000;
		fails++;
		conclude();
	end
endmodule // analog_comparator_control_bench
